// File: hdl/msc_consts.svh
/*
  Constants of the serial slave port supervisor: parameter indices, reset values,
  legal ranges and timing units.
  Assumes it is included by bare name from the supervisor design module only.
*/
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH
// ----------------------------------------------------------------------------
// Clock and timing units
// ----------------------------------------------------------------------------
`define MSC_CLK_HZ         25000000
`define MSC_LAT_UNIT_MS    1
`define MSC_TMO_UNIT_MS    100
// ----------------------------------------------------------------------------
// Parameter indices on the parameter access port
// ----------------------------------------------------------------------------
`define MSC_IDX_BAUD       3'h0
`define MSC_IDX_FMT        3'h1
`define MSC_IDX_ADDR       3'h2
`define MSC_IDX_LAT        3'h3
`define MSC_IDX_TMO        3'h4
`define MSC_IDX_PROTO      3'h5
`define MSC_IDX_RES        3'h6
`define MSC_IDX_ERR        3'h7
`define MSC_ERR_ADDR       16'h8001
// ----------------------------------------------------------------------------
// Reset values and upper limits
// ----------------------------------------------------------------------------
`define MSC_RST_BAUD       16'h0005
`define MSC_RST_FMT        16'h0003
`define MSC_RST_ADDR       16'h0001
`define MSC_RST_LAT        16'h0002
`define MSC_RST_TMO        16'h0000
`define MSC_RST_PROTO      16'h0001
`define MSC_RST_RES        16'h0001
`define MSC_MAX_BAUD       16'h0009
`define MSC_MAX_FMT        16'h0003
`define MSC_MAX_ADDR       16'h00f7
`define MSC_MAX_TMO        16'h0258
`define MSC_MAX_FLAG       16'h0001
`define MSC_MAX_ERR        4'h8
`define MSC_BCAST_ADDR     8'h00
`define MSC_RES_SCALE      16'h000a
`endif

// File: hdl/msc_pkg.sv
/*
  Types of the serial slave port supervisor.
  Assumes msc_consts.svh is on the include path.
*/
package msc_pkg;
  // Communication error codes reported in the status word.
  typedef enum logic [3:0] {
    MSC_ERR_NONE = 4'h0, MSC_ERR_PASSWORD = 4'h1, MSC_ERR_FUNC = 4'h2,
    MSC_ERR_CHECKSUM = 4'h3, MSC_ERR_ADDRESS = 4'h4, MSC_ERR_RANGE = 4'h5,
    MSC_ERR_MODIFY = 4'h6, MSC_ERR_LOCKED = 4'h7, MSC_ERR_NV_BUSY = 4'h8
  } msc_err_t;
  // Character formats.
  typedef enum logic [1:0] {
    MSC_FMT_8N2 = 2'h0, MSC_FMT_8E1 = 2'h1, MSC_FMT_8O1 = 2'h2, MSC_FMT_8N1 = 2'h3
  } msc_fmt_t;
  // Reply sequencing states.
  typedef enum logic [1:0] {
    MSC_IDLE = 2'h0, MSC_WAIT = 2'h1, MSC_SEND = 2'h2
  } msc_rsp_t;
  // Serial bit engine states.
  typedef enum logic [2:0] {
    MSC_B_IDLE = 3'h0, MSC_B_START = 3'h1, MSC_B_DATA = 3'h2, MSC_B_PAR = 3'h3, MSC_B_STOP = 3'h4
  } msc_bit_t;
endpackage : msc_pkg

// File: hdl/msc_uart_if.sv
/*
  Character interface between the supervisor and its serial bit engine.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface msc_uart_if;
  logic [16:0] divisor;
  logic [1:0]  fmt;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic        tx_busy;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_perr;
  modport ctrl (output divisor, fmt, tx_data, tx_valid, input tx_ready, tx_busy, rx_data, rx_valid, rx_perr);
  modport eng  (input divisor, fmt, tx_data, tx_valid, output tx_ready, tx_busy, rx_data, rx_valid, rx_perr);
endinterface : msc_uart_if
`default_nettype wire

// File: hdl/msc_uart.sv
/*
  Serial bit engine: one start bit, eight data bits LSB first, optional parity,
  one or two stop bits, at a bit time of divisor clock cycles.
  Assumes the divisor and format stay stable while a character is in flight.
*/
`timescale 1ns/1ns
`default_nettype none
module msc_uart
  import msc_pkg::*;
(
  // Clock and reset.
  input  wire logic  sys_clk,
  input  wire logic  resetn,
  // Serial pins.
  input  wire logic  rx_pin,
  output var  logic  tx_pin,
  // Character side.
  msc_uart_if.eng    u
);
  logic       rx_s1, rx_s2;
  msc_bit_t   rst, next_rst, tst, next_tst;
  logic [16:0] rcnt, next_rcnt, tcnt, next_tcnt;
  logic [2:0] rbit, next_rbit, tbit, next_tbit;
  logic [7:0] rsh, next_rsh, tsh, next_tsh;
  logic       rvld, next_rvld, rperr, next_rperr, tline, next_tline, tstop2, next_tstop2;
  logic       has_par, par_odd;

  // Format decode for both directions.
  assign has_par  = (u.fmt == MSC_FMT_8E1) || (u.fmt == MSC_FMT_8O1);
  assign par_odd  = (u.fmt == MSC_FMT_8O1);
  assign u.rx_data  = rsh;
  assign u.rx_valid = rvld;
  assign u.rx_perr  = rperr;
  assign u.tx_ready = (tst == MSC_B_IDLE);
  assign u.tx_busy  = (tst != MSC_B_IDLE);
  assign tx_pin     = tline;

  // Receive sequencing, sampled at mid bit.
  always_comb begin
    next_rst = rst; next_rcnt = rcnt; next_rbit = rbit; next_rsh = rsh;
    next_rvld = 1'b0; next_rperr = rperr;
    if (rst != MSC_B_IDLE && rcnt != 17'h0) begin
      next_rcnt = rcnt - 17'h1;
    end else begin
      unique case (rst)
        MSC_B_IDLE:  if (!rx_s2) begin next_rcnt = u.divisor >> 1; next_rst = MSC_B_START; end
        MSC_B_START: begin
          next_rcnt = u.divisor - 17'h1; next_rbit = 3'h0;
          next_rst = rx_s2 ? MSC_B_IDLE : MSC_B_DATA;
        end
        MSC_B_DATA:  begin
          next_rsh = {rx_s2, rsh[7:1]}; next_rcnt = u.divisor - 17'h1; next_rbit = rbit + 3'h1;
          if (rbit == 3'h7) next_rst = has_par ? MSC_B_PAR : MSC_B_STOP;
        end
        MSC_B_PAR:   begin next_rperr = rx_s2 ^ (^rsh) ^ par_odd; next_rcnt = u.divisor - 17'h1; next_rst = MSC_B_STOP; end
        MSC_B_STOP:  begin
          next_rvld = rx_s2; next_rst = MSC_B_IDLE;
          if (!has_par) next_rperr = 1'b0;
        end
        default:     next_rst = MSC_B_IDLE;
      endcase
    end
  end

  // Transmit sequencing.
  always_comb begin
    next_tst = tst; next_tcnt = tcnt; next_tbit = tbit; next_tsh = tsh; next_tline = tline; next_tstop2 = tstop2;
    if (tst != MSC_B_IDLE && tcnt != 17'h0) begin
      next_tcnt = tcnt - 17'h1;
    end else begin
      next_tcnt = u.divisor - 17'h1;
      unique case (tst)
        MSC_B_IDLE:  if (u.tx_valid) begin
          next_tsh = u.tx_data; next_tline = 1'b0; next_tst = MSC_B_START;
          next_tstop2 = (u.fmt == MSC_FMT_8N2);
        end
        MSC_B_START: begin next_tline = tsh[0]; next_tbit = 3'h0; next_tst = MSC_B_DATA; end
        MSC_B_DATA:  begin
          next_tbit = tbit + 3'h1;
          if (tbit == 3'h7) begin
            next_tline = has_par ? ((^tsh) ^ par_odd) : 1'b1;
            next_tst = has_par ? MSC_B_PAR : MSC_B_STOP;
          end else begin
            next_tline = tsh[tbit + 3'h1];
          end
        end
        MSC_B_PAR:   begin next_tline = 1'b1; next_tst = MSC_B_STOP; end
        MSC_B_STOP:  begin
          if (tstop2) next_tstop2 = 1'b0;
          else next_tst = MSC_B_IDLE;
        end
        default:     next_tst = MSC_B_IDLE;
      endcase
      if (tst == MSC_B_IDLE && !u.tx_valid) next_tcnt = tcnt;
    end
  end

  // State registers and input synchroniser.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_s1 <= 1'b1; rx_s2 <= 1'b1; rst <= MSC_B_IDLE; rcnt <= 17'h0; rbit <= 3'h0; rsh <= 8'h00;
      rvld <= 1'b0; rperr <= 1'b0; tst <= MSC_B_IDLE; tcnt <= 17'h0; tbit <= 3'h0; tsh <= 8'h00;
      tline <= 1'b1; tstop2 <= 1'b0;
    end else begin
      rx_s1 <= rx_pin; rx_s2 <= rx_s1; rst <= next_rst; rcnt <= next_rcnt; rbit <= next_rbit;
      rsh <= next_rsh; rvld <= next_rvld; rperr <= next_rperr; tst <= next_tst; tcnt <= next_tcnt;
      tbit <= next_tbit; tsh <= next_tsh; tline <= next_tline; tstop2 <= next_tstop2;
    end
  end
endmodule : msc_uart
`default_nettype wire

// File: hdl/msc_modbus_slave_comm_config.sv
/*
  Configuration and supervision of the serial slave port: parameters, address
  filter, reply latency, link timeout, reply length and current scaling.
  Assumes a frame engine outside decodes frames, supplies reply bytes, and keeps
  req_status within the defined error codes.
*/
//
// Overview of operation
// - Status word holds 0 no fault, 1 password, 2 function, 3 checksum, 4 address.
// - Status word holds 5 range, 6 bad change, 7 locked, 8 storage busy.
// - Bit rate from index 0 (300) to 9 (115200); index resets to 5.
// - Format 0 8N2, 1 8E1, 2 8O1, 3 8N1; resets to 3.
// - Station address 1 to 247, reset 1; address 0 is broadcast.
// - Wait reply latency, reset 2 ms, between request end and reply.
// - Reply starts at the later of processing done and latency elapsed.
// - Timeout of zero disables link supervision entirely.
// - Non-zero timeout raises a fault when the gap between requests reaches it.
// - Protocol 1 standard; protocol 0 adds one byte to read replies.
// - Current readback in 0.01 A when selector is 0, 0.1 A when 1.
`timescale 1ns/1ns
`default_nettype none
`include "msc_consts.svh"
module msc_modbus_slave_comm_config
  import msc_pkg::*;
#(
  parameter int unsigned MS_CYCLES   = `MSC_CLK_HZ / 1000 * `MSC_LAT_UNIT_MS,
  parameter int unsigned TICK_CYCLES = `MSC_CLK_HZ / 1000 * `MSC_TMO_UNIT_MS
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Serial line.
  input  wire logic        rx_pin,
  output var  logic        tx_pin,
  output var  logic        tx_oe_n,
  // Parameter access.
  input  wire logic        par_wr,
  input  wire logic [2:0]  par_idx,
  input  wire logic [15:0] par_wdata,
  output var  logic [15:0] par_rdata,
  // Received characters.
  output var  logic [7:0]  rx_data,
  output var  logic        rx_valid,
  output var  logic        rx_perr,
  // Request and reply events.
  input  wire logic        req_done,
  input  wire logic [7:0]  req_addr,
  input  wire logic [3:0]  req_status,
  output var  logic        req_accept,
  output var  logic        req_reply,
  input  wire logic        proc_done,
  input  wire logic [7:0]  reply_data,
  input  wire logic        reply_valid,
  input  wire logic        reply_last,
  output var  logic        reply_ready,
  // Reply shaping.
  input  wire logic [7:0]  std_byte_count,
  output var  logic [7:0]  reply_byte_count,
  input  wire logic [15:0] current_centiamp,
  output var  logic [15:0] current_reply,
  // Status.
  output var  logic [15:0] comm_error_code,
  output var  logic        comm_fault
);
  localparam logic [31:0] MS_C   = 32'(MS_CYCLES);
  localparam logic [31:0] TICK_C = 32'(TICK_CYCLES);

  msc_uart_if u ();
  logic [15:0] baud_select, char_format_select, station_address, reply_latency;
  logic [15:0] link_timeout, protocol_select, current_resolution;
  logic [15:0] next_baud, next_fmt, next_addr, next_lat, next_tmo, next_proto, next_res, next_rdata;
  msc_rsp_t    rsp, next_rsp;
  logic [31:0] lat_sub, next_lat_sub, tick, next_tick;
  logic [15:0] lat_ms, next_lat_ms, tmo_cnt, next_tmo_cnt;
  logic [3:0]  err, next_err;
  logic        done_seen, next_done_seen, next_fault, for_us, bcast, lat_up;

  // Bit time in clock cycles for a rate index.
  function automatic logic [16:0] baud_div(input logic [15:0] idx);
    logic [31:0] rate;
    rate = 32'd9600;
    unique case (idx[3:0])
      4'h0: rate = 32'd300;   4'h1: rate = 32'd600;   4'h2: rate = 32'd1200;
      4'h3: rate = 32'd2400;  4'h4: rate = 32'd4800;  4'h5: rate = 32'd9600;
      4'h6: rate = 32'd19200; 4'h7: rate = 32'd38400; 4'h8: rate = 32'd57600;
      default: rate = 32'd115200;
    endcase
    return 17'(32'(`MSC_CLK_HZ) / rate);
  endfunction : baud_div

  // ---------------------------------------------------------------------------
  // Parameter registers
  // ---------------------------------------------------------------------------
  // Writes outside the legal range leave the parameter unchanged.
  always_comb begin
    next_baud = baud_select; next_fmt = char_format_select; next_addr = station_address;
    next_lat = reply_latency; next_tmo = link_timeout; next_proto = protocol_select;
    next_res = current_resolution;
    if (par_wr) begin
      unique case (par_idx)
        `MSC_IDX_BAUD:  if (par_wdata <= `MSC_MAX_BAUD) next_baud = par_wdata;
        `MSC_IDX_FMT:   if (par_wdata <= `MSC_MAX_FMT) next_fmt = par_wdata;
        `MSC_IDX_ADDR:  if (par_wdata != 16'h0 && par_wdata <= `MSC_MAX_ADDR) next_addr = par_wdata;
        `MSC_IDX_LAT:   next_lat = par_wdata;
        `MSC_IDX_TMO:   if (par_wdata <= `MSC_MAX_TMO) next_tmo = par_wdata;
        `MSC_IDX_PROTO: if (par_wdata <= `MSC_MAX_FLAG) next_proto = par_wdata;
        `MSC_IDX_RES:   if (par_wdata <= `MSC_MAX_FLAG) next_res = par_wdata;
        default:        next_baud = baud_select;
      endcase
    end
    unique case (par_idx)
      `MSC_IDX_BAUD:  next_rdata = baud_select;
      `MSC_IDX_FMT:   next_rdata = char_format_select;
      `MSC_IDX_ADDR:  next_rdata = station_address;
      `MSC_IDX_LAT:   next_rdata = reply_latency;
      `MSC_IDX_TMO:   next_rdata = link_timeout;
      `MSC_IDX_PROTO: next_rdata = protocol_select;
      `MSC_IDX_RES:   next_rdata = current_resolution;
      default:        next_rdata = comm_error_code;
    endcase
  end

  // Parameter storage with factory values.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      baud_select <= `MSC_RST_BAUD; char_format_select <= `MSC_RST_FMT; station_address <= `MSC_RST_ADDR;
      reply_latency <= `MSC_RST_LAT; link_timeout <= `MSC_RST_TMO; protocol_select <= `MSC_RST_PROTO;
      current_resolution <= `MSC_RST_RES; par_rdata <= 16'h0000;
    end else begin
      baud_select <= next_baud; char_format_select <= next_fmt; station_address <= next_addr;
      reply_latency <= next_lat; link_timeout <= next_tmo; protocol_select <= next_proto;
      current_resolution <= next_res; par_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Serial engine and reply path
  // ---------------------------------------------------------------------------
  // Bit rate, format and the reply byte stream go to the engine.
  assign u.divisor  = baud_div(baud_select);
  assign u.fmt      = char_format_select[1:0];
  assign u.tx_data  = reply_data;
  assign u.tx_valid = (rsp == MSC_SEND) && reply_valid;
  assign reply_ready = (rsp == MSC_SEND) && u.tx_ready;
  assign rx_data  = u.rx_data;
  assign rx_valid = u.rx_valid;
  assign rx_perr  = u.rx_perr;
  assign tx_oe_n  = !((rsp == MSC_SEND) || u.tx_busy);

  msc_uart i_uart (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .rx_pin  (rx_pin),
    .tx_pin  (tx_pin),
    .u       (u.eng)
  );

  // Address filter: own station or broadcast.
  assign for_us     = req_done && ({8'h00, req_addr} == station_address);
  assign bcast      = req_done && (req_addr == `MSC_BCAST_ADDR);
  assign req_accept = for_us || bcast;
  assign req_reply  = for_us;
  assign lat_up     = (lat_ms >= reply_latency);

  // ---------------------------------------------------------------------------
  // Reply sequencing and error status
  // ---------------------------------------------------------------------------
  // A request to this station waits for both processing and the latency.
  always_comb begin
    next_rsp = rsp; next_lat_sub = lat_sub; next_lat_ms = lat_ms; next_done_seen = done_seen; next_err = err;
    if (req_accept) next_err = (req_status > `MSC_MAX_ERR) ? MSC_ERR_NONE : req_status;
    unique case (rsp)
      MSC_IDLE: if (for_us) begin
        next_rsp = MSC_WAIT; next_lat_sub = 32'h0; next_lat_ms = 16'h0; next_done_seen = proc_done;
      end
      MSC_WAIT: begin
        if (proc_done) next_done_seen = 1'b1;
        if (!lat_up) begin
          next_lat_sub = (lat_sub == MS_C - 32'h1) ? 32'h0 : lat_sub + 32'h1;
          if (lat_sub == MS_C - 32'h1) next_lat_ms = lat_ms + 16'h1;
        end
        if (done_seen && lat_up) next_rsp = MSC_SEND;
      end
      MSC_SEND: if (reply_valid && u.tx_ready && reply_last) next_rsp = MSC_IDLE;
      default:  next_rsp = MSC_IDLE;
    endcase
  end

  // Reply sequencing registers.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rsp <= MSC_IDLE; lat_sub <= 32'h0; lat_ms <= 16'h0; done_seen <= 1'b0; err <= MSC_ERR_NONE;
    end else begin
      rsp <= next_rsp; lat_sub <= next_lat_sub; lat_ms <= next_lat_ms; done_seen <= next_done_seen; err <= next_err;
    end
  end

  // ---------------------------------------------------------------------------
  // Link timeout and reply shaping
  // ---------------------------------------------------------------------------
  // Gap counted in 0.1 s units since the last accepted request.
  always_comb begin
    next_tick = tick; next_tmo_cnt = tmo_cnt; next_fault = comm_fault;
    if (link_timeout == 16'h0) begin
      next_tick = 32'h0; next_tmo_cnt = 16'h0; next_fault = 1'b0;
    end else if (req_accept) begin
      next_tick = 32'h0; next_tmo_cnt = 16'h0; next_fault = 1'b0;
    end else if (tick == TICK_C - 32'h1) begin
      next_tick = 32'h0;
      if (tmo_cnt != 16'hffff) next_tmo_cnt = tmo_cnt + 16'h1;
      if (tmo_cnt + 16'h1 >= link_timeout) next_fault = 1'b1;
    end else begin
      next_tick = tick + 32'h1;
    end
  end

  // Timeout registers and shaped reply values.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tick <= 32'h0; tmo_cnt <= 16'h0; comm_fault <= 1'b0; reply_byte_count <= 8'h00; current_reply <= 16'h0000;
    end else begin
      tick <= next_tick; tmo_cnt <= next_tmo_cnt; comm_fault <= next_fault;
      reply_byte_count <= std_byte_count + {7'h00, (protocol_select == 16'h0)};
      current_reply <= (current_resolution == 16'h0) ? current_centiamp
                                                      : current_centiamp / `MSC_RES_SCALE;
    end
  end

  assign comm_error_code = {12'h000, err};

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_err_load; req_accept && req_status <= `MSC_MAX_ERR |=> comm_error_code == {12'h000, $past(req_status)}; endproperty
  a_err_load: assert property (p_err_load) else $error("Error code not loaded.");
  property p_err_hold; !req_accept |=> $stable(comm_error_code) && comm_error_code <= 16'h0008; endproperty
  a_err_hold: assert property (p_err_hold) else $error("Error code changed without request.");
  property p_baud; par_wr && par_idx == `MSC_IDX_BAUD && par_wdata == `MSC_MAX_BAUD |=> u.divisor == 17'd217; endproperty
  a_baud: assert property (p_baud) else $error("Fastest rate divisor wrong.");
  property p_fmt; par_wr && par_idx == `MSC_IDX_FMT && par_wdata == 16'h0 |=> u.fmt == MSC_FMT_8N2; endproperty
  a_fmt: assert property (p_fmt) else $error("Format not applied.");
  property p_other; rsp == MSC_IDLE && req_done && !req_accept |=> rsp == MSC_IDLE ##1 rsp == MSC_IDLE; endproperty
  a_other: assert property (p_other) else $error("Foreign frame answered.");
  property p_lat; rsp == MSC_WAIT && !lat_up |=> rsp != MSC_SEND; endproperty
  a_lat: assert property (p_lat) else $error("Reply before latency.");
  property p_go; rsp == MSC_WAIT && done_seen && lat_up |=> rsp == MSC_SEND; endproperty
  a_go: assert property (p_go) else $error("Ready reply held back.");
  property p_off; link_timeout == 16'h0 |=> !comm_fault; endproperty
  a_off: assert property (p_off) else $error("Fault with supervision off.");
  property p_tmo; $rose(comm_fault) |-> tmo_cnt >= link_timeout && link_timeout != 16'h0; endproperty
  a_tmo: assert property (p_tmo) else $error("Fault before timeout.");
  property p_len; protocol_select == 16'h0 |=> reply_byte_count == $past(std_byte_count) + 8'h01; endproperty
  a_len: assert property (p_len) else $error("Non-standard length wrong.");
  property p_cur; current_resolution == 16'h0 |=> current_reply == $past(current_centiamp); endproperty
  a_cur: assert property (p_cur) else $error("Fine current scaling wrong.");
  property p_bc; rsp == MSC_IDLE && bcast && !u.tx_busy |=> tx_oe_n [*2]; endproperty
  a_bc: assert property (p_bc) else $error("Broadcast answered.");
endmodule : msc_modbus_slave_comm_config
`default_nettype wire

// File: dv/msc_host_model.sv
/*
  Host master model on the serial line; it listens to replies.
  Assumes the device shares the system clock and sends at DIV cycles a bit.
*/
`timescale 1ns/1ns
`default_nettype none
module msc_host_model #(
  parameter int unsigned DIV = 217
) (
  // Clock and serial line.
  input  wire logic       sys_clk,
  input  wire logic       tx_pin,
  output var  logic       rx_pin,
  output var  logic [7:0] got_byte
);
  // The host keeps its own line idle high.
  initial rx_pin = 1'b1;
  // Sends one character at DIV cycles a bit: start, data LSB first, optional parity, one stop.
  task automatic send(input logic [7:0] b, input logic par_en, input logic par_bit);
    rx_pin <= 1'b0;
    repeat (DIV) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      rx_pin <= b[i];
      repeat (DIV) @(posedge sys_clk);
    end
    if (par_en) begin
      rx_pin <= par_bit;
      repeat (DIV) @(posedge sys_clk);
    end
    rx_pin <= 1'b1;
    repeat (DIV) @(posedge sys_clk);
  endtask : send
  // Samples each reply character at mid-bit, least significant bit first.
  initial begin
    got_byte = 8'h00;
    forever begin
      @(negedge tx_pin);
      repeat (DIV / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge sys_clk);
        got_byte[i] = tx_pin;
      end
      repeat (DIV) @(posedge sys_clk);
    end
  end
endmodule : msc_host_model
`default_nettype wire

// File: dv/tb_modbus_slave_comm_config.sv
/*
  Self-checking testbench of the serial slave port supervisor.
  Assumes the design files and the host model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_modbus_slave_comm_config;
  logic        sys_clk, resetn, rx_pin, tx_pin, tx_oe_n, par_wr, req_done, req_accept, req_reply, proc_done;
  logic        reply_valid, reply_last, reply_ready, comm_fault, rx_valid, rx_perr;
  logic [2:0]  par_idx;
  logic [3:0]  req_status;
  logic [7:0]  req_addr, reply_data, std_byte_count, reply_byte_count, rx_data, host_byte;
  logic [15:0] par_wdata, par_rdata, current_centiamp, current_reply, comm_error_code;
  logic [15:0] rv[7] = '{16'h0005, 16'h0003, 16'h0001, 16'h0002, 16'h0000, 16'h0001, 16'h0001};
  int          num_errors = 0, n_checks = 0, n;
  msc_modbus_slave_comm_config #(.MS_CYCLES(4), .TICK_CYCLES(8)) i_msc_modbus_slave_comm_config (.sys_clk,
    .resetn, .rx_pin, .tx_pin, .tx_oe_n, .par_wr, .par_idx, .par_wdata, .par_rdata, .rx_data, .rx_valid,
    .rx_perr, .req_done, .req_addr, .req_status, .req_accept, .req_reply, .proc_done, .reply_data,
    .reply_valid, .reply_last, .reply_ready, .std_byte_count, .reply_byte_count, .current_centiamp,
    .current_reply, .comm_error_code, .comm_fault);
  msc_host_model i_msc_host_model (.sys_clk, .tx_pin, .rx_pin, .got_byte(host_byte));
  logic [8:0]  rx_seen = 9'h000;
  // Keeps the last received character with its parity error flag.
  always @(posedge sys_clk) if (rx_valid) rx_seen <= {rx_perr, rx_data};
  // Clock of 40 ns.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Counts and reports one comparison.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Writes one parameter in a one-cycle strobe.
  task automatic wr(input logic [2:0] i, input logic [15:0] d);
    par_idx = i;
    par_wdata = d;
    par_wr = 1'b1;
    @(posedge sys_clk);
    #1 par_wr = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : wr
  // Reads one parameter two edges after the index is set.
  task automatic rd(input logic [2:0] i, input logic [15:0] e);
    par_idx = i;
    repeat (2) @(posedge sys_clk);
    #1 chk(par_rdata, e);
  endtask : rd
  // Pulses a finished request and judges its filtering.
  task automatic req(input logic [7:0] a, input logic [3:0] s, input logic acc, input logic rep);
    req_addr = a;
    req_status = s;
    req_done = 1'b1;
    #1 chk(req_accept, acc);
    chk(req_reply, rep);
    @(posedge sys_clk);
    #1 req_done = 1'b0;
  endtask : req
  // Checks reset values, then refused and accepted writes.
  task automatic t_params();
    for (int i = 0; i < 7; i++) rd(i[2:0], rv[i]);
    wr(3'h2, 16'h0000);
    rd(3'h2, 16'h0001);
    wr(3'h0, 16'h000a);
    rd(3'h0, 16'h0005);
    wr(3'h0, 16'h0009);
    wr(3'h1, 16'h0000);
    rd(3'h1, 16'h0000);
    wr(3'h1, 16'h0004);
    rd(3'h1, 16'h0000);
    wr(3'h2, 16'h00f7);
    rd(3'h2, 16'h00f7);
  endtask : t_params
  // Walks every status code by broadcast; a foreign frame leaves it alone.
  task automatic t_status();
    for (int s = 0; s < 9; s++) begin
      req(8'h00, s[3:0], 1'b1, 1'b0);
      rd(3'h7, s[15:0]);
    end
    req(8'h05, 4'h3, 1'b0, 1'b0);
    rd(3'h7, 16'h0008);
    chk(comm_error_code, 16'h0008);
  endtask : t_status
  // Times one reply from request to ready, then sends one byte on the line.
  task automatic t_reply(input logic [15:0] lat, input int pd, input int lo, input int hi, input logic [7:0] b);
    wr(3'h3, lat);
    proc_done = (pd == 0);
    req(8'hf7, 4'h0, 1'b1, 1'b1);
    n = 0;
    while (reply_ready !== 1'b1 && n < 200) begin
      if (n == pd) proc_done = 1'b1;
      @(posedge sys_clk);
      #1 n++;
    end
    chk(n >= lo && n <= hi, 1'b1);
    chk(tx_oe_n, 1'b0);
    reply_data = b;
    {reply_valid, reply_last} = 2'b11;
    @(posedge sys_clk);
    #1 {reply_valid, reply_last, proc_done} = 3'b000;
    n = 0;
    while (tx_oe_n !== 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(tx_oe_n, 1'b1);
    chk(host_byte, b);
  endtask : t_reply
  // Checks reply length and current scaling for both selector values.
  task automatic t_shape();
    chk(current_reply, 16'h007b);
    chk(reply_byte_count, 8'h10);
    wr(3'h5, 16'h0000);
    wr(3'h6, 16'h0000);
    repeat (2) @(posedge sys_clk);
    #1 chk(reply_byte_count, 8'h11);
    chk(current_reply, 16'h04d2);
  endtask : t_shape
  // Link supervision stays silent at zero, then trips on a one tick gap.
  task automatic t_timeout();
    repeat (30) @(posedge sys_clk);
    #1 chk(comm_fault, 1'b0);
    wr(3'h4, 16'h0001);
    req(8'h00, 4'h0, 1'b1, 1'b0);
    repeat (4) @(posedge sys_clk);
    #1 chk(comm_fault, 1'b0);
    repeat (10) @(posedge sys_clk);
    #1 chk(comm_fault, 1'b1);
    req(8'h00, 4'h0, 1'b1, 1'b0);
    chk(comm_fault, 1'b0);
  endtask : t_timeout
  // The host sends one character in the set format; the device delivers it and flags parity.
  task automatic t_rx(input logic [7:0] b, input logic pe, input logic pb, input logic [8:0] e);
    i_msc_host_model.send(b, pe, pb);
    #1 chk(rx_seen, e);
  endtask : t_rx
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // Main sequence.
  initial begin
    {resetn, par_wr, req_done, proc_done, reply_valid, reply_last} = 6'h00;
    {par_idx, par_wdata, req_addr, req_status, reply_data} = '0;
    std_byte_count = 8'h10;
    current_centiamp = 16'h04d2;
    repeat (8) @(posedge sys_clk);
    #1 resetn = 1'b1;
    t_params();
    t_rx(8'ha5, 1'b0, 1'b0, 9'h0a5);
    t_status();
    t_reply(16'h0002, 0, 9, 11, 8'ha5);
    wr(3'h1, 16'h0001);
    t_rx(8'h3c, 1'b1, 1'b0, 9'h03c);
    t_rx(8'h3c, 1'b1, 1'b1, 9'h13c);
    t_reply(16'h0000, 20, 21, 24, 8'h3c);
    t_shape();
    t_timeout();
    end_sim();
  end
  // Watchdog well beyond the expected run.
  initial begin
    #(40 * 60000);
    num_errors++;
    end_sim();
  end
endmodule : tb_modbus_slave_comm_config
`default_nettype wire
